// ==== rtl/polarity_detect_pkg.sv ====
package polarity_detect_pkg;

    // ----------------------------------------------------------------
    // encoder kinds
    // ----------------------------------------------------------------
    localparam logic ENC_INCREMENTAL = 1'h0;
    localparam logic ENC_ABSOLUTE    = 1'h1;

    // ----------------------------------------------------------------
    // polarity sensor option
    // ----------------------------------------------------------------
    localparam logic OPT_USE_SENSOR = 1'h0;
    localparam logic OPT_NO_SENSOR  = 1'h1;

    // ----------------------------------------------------------------
    // pin allocation codes for the detect request
    // ----------------------------------------------------------------
    localparam logic [3:0] ALLOC_UNUSED = 4'h0;
    localparam logic [3:0] ALLOC_ALWAYS = 4'h7;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic       RST_DONE      = 1'h0;
    localparam logic [7:0] RST_RUN_COUNT = 8'h00;
    localparam int         RUN_TIME_US   = 4;
    localparam int         CLOCK_MHZ     = 40;
    localparam int         RUN_CYCLES    = RUN_TIME_US * CLOCK_MHZ;

endpackage

// ==== rtl/polarity_edge_detect.sv ====
`timescale 1ns/1ps
`default_nettype none

module polarity_edge_detect (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // level in, pulse out
    input  wire logic level_i,
    output logic      rise_o
);

    typedef struct packed {
        logic last;
        logic rise;
    } edge_state_t;

    edge_state_t state;
    edge_state_t next_state;

    always_comb begin
        next_state      = state;
        next_state.last = level_i;
        next_state.rise = level_i && !state.last;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rise_o = state.rise;

endmodule

`default_nettype wire

// ==== rtl/linear_motor_polarity_detect_seq.sv ====
`timescale 1ns/1ps
`default_nettype none

module linear_motor_polarity_detect_seq #(
    parameter int RUN_CYCLES = polarity_detect_pkg::RUN_CYCLES
) (
    // clock and reset (reset models control power-up)
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // configuration
    input  wire logic       linear_motor_option_setting_i,
    input  wire logic       encoder_absolute_i,
    input  wire logic [3:0] input_pin_allocation_setting_i,
    input  wire logic       motorless_test_setting_i,
    input  wire logic       param_write_protect_i,
    // drive status
    input  wire logic       main_power_on_i,
    input  wire logic       hardwire_base_block_i,
    input  wire logic       alarm_other_i,
    input  wire logic       alarm_phase_disagree_i,
    input  wire logic       overtravel_i,
    input  wire logic       sensor_present_i,
    input  wire logic       abs_polarity_stored_i,
    // host signals
    input  wire logic       servo_on_i,
    input  wire logic       polarity_detect_request_i,
    input  wire logic       polarity_detect_utility_i,
    // motion engine handshake
    input  wire logic       detect_ok_i,
    // outputs
    output logic            motor_power_o,
    output logic            detect_running_o,
    output logic            polarity_valid_o,
    output logic            servo_ready_o,
    output logic            sensor_alarm_o,
    output logic            store_polarity_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN  = 3'h2,
        ST_ON   = 3'h4
    } seq_state_t;

    typedef struct packed {
        seq_state_t fsm;
        logic       done;
        logic [7:0] count;
        logic       from_tool;
        logic       main_last;
        logic       motor_power;
        logic       ready;
        logic       alarm;
        logic       store;
        logic       son_last;
        logic       valid_out;
        logic       running;
    } ctl_state_t;

    ctl_state_t state;
    ctl_state_t next_state;
    logic       req_rise;
    logic       utility_rise;
    logic       req_level;
    logic       precond;
    logic       valid;
    logic       start_son;
    logic       start_req;
    logic       start_tool;

    // ----------------------------------------------------------------
    // edge detectors
    // ----------------------------------------------------------------
    polarity_edge_detect req_edge (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .level_i (req_level),
        .rise_o  (req_rise)
    );

    polarity_edge_detect util_edge (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .level_i (polarity_detect_utility_i),
        .rise_o  (utility_rise)
    );

    // ----------------------------------------------------------------
    // trigger qualification
    // ----------------------------------------------------------------
    always_comb begin
        // unallocated pin has no effect; always-active follows main power
        req_level = (input_pin_allocation_setting_i == polarity_detect_pkg::ALLOC_ALWAYS)
                    ? main_power_on_i
                    : ((input_pin_allocation_setting_i != polarity_detect_pkg::ALLOC_UNUSED)
                       && polarity_detect_request_i);
        precond   = (linear_motor_option_setting_i == polarity_detect_pkg::OPT_NO_SENSOR)
                    && main_power_on_i && !hardwire_base_block_i
                    && !alarm_other_i
                    && !motorless_test_setting_i && !overtravel_i;
        // absolute encoder keeps stored polarity; incremental starts empty
        valid     = state.done
                    || (encoder_absolute_i && abs_polarity_stored_i);
        start_son  = servo_on_i && !state.son_last && !valid && !encoder_absolute_i;
        start_req  = req_rise && !valid && !encoder_absolute_i;
        start_tool = utility_rise && !param_write_protect_i;
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state           = state;
        next_state.store     = 1'h0;
        next_state.main_last = main_power_on_i;
        next_state.son_last  = servo_on_i && state.fsm == ST_IDLE && precond;
        // sensor option with no sensor fitted flags an alarm after restart
        next_state.alarm     = state.alarm
                               || ((linear_motor_option_setting_i
                                    == polarity_detect_pkg::OPT_USE_SENSOR)
                                   && !sensor_present_i);
        case (state.fsm)
            ST_IDLE: begin
                next_state.motor_power = 1'h0;
                next_state.ready       = 1'h0;
                if (precond && (start_son || start_req || start_tool)) begin
                    next_state.fsm         = ST_RUN;
                    next_state.motor_power = 1'h1;
                    next_state.count       = polarity_detect_pkg::RST_RUN_COUNT;
                    next_state.from_tool   = start_tool;
                end else if (valid && servo_on_i && precond
                             && linear_motor_option_setting_i
                                == polarity_detect_pkg::OPT_NO_SENSOR) begin
                    next_state.fsm         = ST_ON;
                    next_state.motor_power = 1'h1;
                    next_state.ready       = 1'h1;
                end
            end
            ST_RUN: begin
                if (!main_power_on_i || hardwire_base_block_i || alarm_other_i
                    || overtravel_i) begin
                    next_state.fsm         = ST_IDLE;
                    next_state.motor_power = 1'h0;
                end else if (detect_ok_i
                             || state.count == 8'(RUN_CYCLES - 1)) begin
                    next_state.done  = 1'h1;
                    next_state.store = encoder_absolute_i;
                    next_state.ready = 1'h1;
                    next_state.fsm   = ST_ON;
                end else begin
                    next_state.count = state.count + 8'h01;
                end
            end
            ST_ON: begin
                // tool runs drop the servo afterwards unless servo-on is held
                if (!servo_on_i && !(!state.from_tool && req_level)) begin
                    next_state.fsm         = ST_IDLE;
                    next_state.motor_power = 1'h0;
                    next_state.ready       = 1'h0;
                end
                if (hardwire_base_block_i || alarm_other_i || !main_power_on_i) begin
                    next_state.fsm         = ST_IDLE;
                    next_state.motor_power = 1'h0;
                    next_state.ready       = 1'h0;
                end
            end
            default: begin
                next_state.fsm = ST_IDLE;
            end
        endcase
        next_state.running   = (next_state.fsm == ST_RUN);
        // valid shows together with ready at the completing edge
        next_state.valid_out = next_state.done
                               || (encoder_absolute_i && abs_polarity_stored_i);
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state       <= '0;
            state.fsm   <= ST_IDLE;
            state.done  <= polarity_detect_pkg::RST_DONE;
            state.count <= polarity_detect_pkg::RST_RUN_COUNT;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // output flops
    // ----------------------------------------------------------------
    assign motor_power_o    = state.motor_power;
    assign detect_running_o = state.running;
    assign polarity_valid_o = state.valid_out;
    assign servo_ready_o    = state.ready;
    assign sensor_alarm_o   = state.alarm;
    assign store_polarity_o = state.store;

endmodule

`default_nettype wire

// ==== dv/polarity_detect_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module polarity_detect_properties #(
    parameter int RUN_CYCLES = polarity_detect_pkg::RUN_CYCLES
) (
    // clock and reset
    input wire logic       clock_i,
    input wire logic       rst_n_i,
    // inputs
    input wire logic       encoder_absolute_i,
    input wire logic [3:0] input_pin_allocation_setting_i,
    input wire logic       servo_on_i,
    input wire logic       polarity_detect_request_i,
    input wire logic       polarity_detect_utility_i,
    // outputs
    input wire logic       motor_power_o,
    input wire logic       detect_running_o,
    input wire logic       polarity_valid_o,
    input wire logic       servo_ready_o,
    input wire logic       store_polarity_o
);
    localparam int RUN_MAX = RUN_CYCLES + 2;
    logic idle;
    logic abs_quiet;
    assign idle = ~servo_on_i & ~polarity_detect_request_i & ~detect_running_o
                & (input_pin_allocation_setting_i != polarity_detect_pkg::ALLOC_ALWAYS);
    assign abs_quiet = encoder_absolute_i & ~polarity_detect_utility_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    AST_READY_NEEDS_POLARITY: assert property (servo_ready_o |-> polarity_valid_o)
        else $error("servo ready without polarity");
    AST_RUN_POWERED: assert property (detect_running_o |-> motor_power_o)
        else $error("detection without motor power");
    AST_SERVO_OFF: assert property (idle [*2] |-> !motor_power_o)
        else $error("motor power with servo off");
    AST_ONE_RUN: assert property (polarity_valid_o |=> !$rose(detect_running_o))
        else $error("second detection run");
    AST_ABS_TOOL: assert property (abs_quiet [*3] |-> !$rose(detect_running_o))
        else $error("absolute run not from tool");
    AST_VALID_FROM_RUN: assert property ($rose(polarity_valid_o) && !encoder_absolute_i
        |-> $past(detect_running_o)) else $error("polarity valid without a run");
    AST_STORE_PULSE: assert property (store_polarity_o
        |-> encoder_absolute_i ##1 !store_polarity_o) else $error("store pulse not single");
    AST_RUN_BOUNDED: assert property ($rose(detect_running_o)
        |-> ##[1:RUN_MAX] !detect_running_o) else $error("detection run too long");
endmodule
bind linear_motor_polarity_detect_seq polarity_detect_properties #(.RUN_CYCLES(RUN_CYCLES)) chk (.*);
`default_nettype wire

// ==== dv/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host and motion engine; cmd is {servo on, follow ready, request, prompt answer}
module host_model (
    // clock, reset and bench commands
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic [3:0] cmd_i,
    input  wire logic       ready_i,
    input  wire logic       running_i,
    // host pins and engine answer
    output logic            servo_on_o,
    output logic            request_o,
    output logic            detect_ok_o
);
    logic [2:0] lag;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {servo_on_o, request_o, detect_ok_o, lag} <= 6'h00;
        end else begin
            servo_on_o  <= cmd_i[3] | (cmd_i[2] & ready_i);
            request_o   <= cmd_i[1];
            lag         <= running_i ? lag + 3'h1 : 3'h0;
            detect_ok_o <= running_i & cmd_i[0] & (lag == 3'h3);
        end
    end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    logic       clock_i = 1'b0, rst_n_i = 1'b0, smp = 1'b0, opt = 1'b1, enc = 1'b0;
    logic       wp = 1'b0, util = 1'b0, pd = 1'b0, sens = 1'b1, stored = 1'b0;
    logic [3:0] cmd = 4'h1, alloc = 4'h1;
    logic [4:0] blk = 5'h00;
    logic [9:0] n, q[$];
    int         errors = 0, total_checks = 0, stores = 0;
    wire logic  son, req, ok, power, ready, valid, run, alarm, store;
    wire logic [4:0] out = {power, ready, valid, run, alarm};
    host_model host (.clock_i, .rst_n_i, .cmd_i(cmd), .ready_i(ready), .running_i(run),
        .servo_on_o(son), .request_o(req), .detect_ok_o(ok));
    linear_motor_polarity_detect_seq #(.RUN_CYCLES(8)) DUT (.clock_i, .rst_n_i,
        .linear_motor_option_setting_i(opt), .encoder_absolute_i(enc),
        .input_pin_allocation_setting_i(alloc), .motorless_test_setting_i(blk[3]),
        .param_write_protect_i(wp), .main_power_on_i(~blk[4]), .hardwire_base_block_i(blk[0]),
        .alarm_other_i(blk[1]), .alarm_phase_disagree_i(pd), .overtravel_i(blk[2]),
        .sensor_present_i(sens), .abs_polarity_stored_i(stored), .servo_on_i(son),
        .polarity_detect_request_i(req), .polarity_detect_utility_i(util), .detect_ok_i(ok),
        .motor_power_o(power), .detect_running_o(run), .polarity_valid_o(valid),
        .servo_ready_o(ready), .sensor_alarm_o(alarm), .store_polarity_o(store));
    task automatic cyc(input int k);
        repeat (k) @(posedge clock_i);
    endtask
    task automatic note(input logic [4:0] m, input logic [4:0] e);
        cyc(1);
        q.push_back({m, e});
        smp <= 1'b1;
        cyc(1);
        smp <= 1'b0;
    endtask
    task automatic wait_on(input int b);
        for (int i = 0; i < 60 && out[b] !== 1'b1; i++) @(negedge clock_i);
    endtask
    task automatic boot();
        cyc(1);
        rst_n_i <= 1'b0;
        cyc(10);
        rst_n_i <= 1'b1;
        cyc(2);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial forever #12.5 clock_i = ~clock_i;
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
    // monitor: oldest note against masked outputs
    always @(negedge clock_i) begin
        if (store === 1'b1) begin
            stores++;
        end
        if (smp) begin
            n = q.pop_front();
            `CHK(out & n[9:5], n[4:0])
        end
    end
    initial begin
        void'($urandom(32'h0dc35981));
        boot();
        cmd <= 4'h9;
        wait_on(1);
        note(5'h1F, 5'h12);
        wait_on(3);
        note(5'h1F, 5'h1C);
        cmd <= 4'h1;
        cyc(4);
        note(5'h18, 5'h00);
        cmd <= 4'h9;
        cyc(4);
        note(5'h1E, 5'h1C);
        cmd <= 4'hB;
        cyc(4);
        note(5'h1E, 5'h1C);
        cmd <= 4'h1;
        boot();
        note(5'h04, 5'h00);
        // each blocker alone, then a slow engine ending by timeout
        for (int i = 0; i < 5; i++) begin
            {blk, pd, cmd} <= {5'h01 << i, 1'($urandom), 4'h7};
            cyc(5);
            note(5'h1E, 5'h00);
            {blk, cmd} <= {5'h00, 4'h5};
            cyc(2);
        end
        {pd, cmd} <= {1'b1, 4'h6};
        wait_on(3);
        note(5'h1E, 5'h1C);
        cmd <= 4'h4;
        cyc(2);
        cmd <= 4'h6;
        cyc(5);
        note(5'h1E, 5'h1C);
        {alloc, cmd} <= {4'h0, 4'h3};
        boot();
        note(5'h1E, 5'h00);
        {alloc, blk, cmd} <= {4'h7, 5'h10, 4'h1};
        cyc(3);
        blk <= 5'h00;
        wait_on(2);
        note(5'h06, 5'h04);
        // absolute encoder
        {alloc, enc, cmd} <= {4'h1, 1'b1, 4'hB};
        boot();
        note(5'h1E, 5'h00);
        {cmd, wp, util} <= {4'h1, 2'b11};
        cyc(4);
        note(5'h06, 5'h00);
        {wp, util} <= 2'b00;
        cyc(2);
        util <= 1'b1;
        wait_on(2);
        note(5'h06, 5'h04);
        {util, stored} <= 2'b01;
        boot();
        note(5'h06, 5'h04);
        // sensor option with no sensor fitted
        {enc, stored, opt, sens, cmd} <= 8'h03;
        boot();
        note(5'h13, 5'h01);
        `CHK(stores, 1)
        print_verdict();
    end
endmodule
`default_nettype wire
